/* logic/rxclk_gate_pkg.sv */
// Constants, field layouts and carrier types of the recovered clock gating
// and high-speed tap status register group. Assumes a 16-bit management
// port already decoded from the serial management frames.
//
// Function
// (R1) Flatline enable set: fault holds clock static
// (R2) Flatline enable clear: clock keeps toggling
// (R3) Powerdown enable set: fault powers buffer down
// (R4) Powerdown enable clear: buffer stays powered
// (R5) Station keeps both enable bits at one
// (R6) Station writes one to bits 6 and 5
// (R7) Bits 1 and 0 reset to one
// (R8) Report final autozero cal and filter update
// (R9) Report final first postcursor weight, bits 12:8
// (R10) Report final precursor weight, bits 7:4
// (R11) Report final second postcursor weight, bits 3:0
// (R12) Three reserved controls read/write, reset zero
// (R13) Override bit selects written over internal value
// (R14) Status follows applied setting, no latching

package rxclk_gate_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [15:0] OFS_GATING_CTRL = 16'h8021;
    localparam logic [15:0] OFS_RSVD_A = 16'h8022;
    localparam logic [15:0] OFS_RSVD_B = 16'h8023;
    localparam logic [15:0] OFS_RSVD_C = 16'h8024;
    localparam logic [15:0] OFS_RSVD_READBACK = 16'h8030;
    localparam logic [15:0] OFS_TAP_STATUS = 16'h8031;

    ////////////////////////////////////////////////////////////////////////
    // Gating control layout; bits 15:8 are not implemented and read zero
    localparam int CTRL_W = 8;
    localparam int BIT_FLATLINE_EN = 3;
    localparam int BIT_BUF_OFF_EN = 2;
    localparam logic [CTRL_W-1:0] GATING_CTRL_RST = 8'h0f;
    localparam logic [15:0] RSVD_RST = 16'h0000;
    localparam logic [15:0] READBACK_VAL = 16'h0000;
    localparam logic [15:0] UNMAPPED_VAL = 16'h0000;
    localparam int NUM_RSVD = 3;

    ////////////////////////////////////////////////////////////////////////
    // Serializer settings, packed in the same order as the status word
    typedef struct packed {
        logic [1:0] final_autozero_cal;
        logic final_filter_update;
        logic [4:0] final_first_postcursor_weight;
        logic [3:0] final_precursor_weight;
        logic [3:0] final_second_postcursor_weight;
    } tap_set_t;

    typedef struct packed {
        logic autozero_cal;
        logic filter_update;
        logic first_postcursor;
        logic precursor;
        logic second_postcursor;
    } tap_override_t;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } mgmt_rsp_t;

endpackage

/* logic/fault_sync.sv */
// Two-stage synchroniser for the analog lock and loss-of-signal levels.
// Assumes the inputs are asynchronous levels with no glitch filtering needed.
`timescale 1ns/1ps
`default_nettype none

module fault_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule
`default_nettype wire

/* logic/tap_select.sv */
// Per-field override selection of the high-speed serializer settings.
// Assumes override flags and written values come from same-clock registers.
`timescale 1ns/1ps
`default_nettype none

module tap_select (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Sources
    input wire rxclk_gate_pkg::tap_override_t override_i,
    input wire rxclk_gate_pkg::tap_set_t manual_i,
    input wire rxclk_gate_pkg::tap_set_t internal_i,
    // Applied setting
    output rxclk_gate_pkg::tap_set_t applied_o
);

    logic [15:0] mask;
    logic [15:0] applied_d;
    logic [15:0] applied_q;

    assign mask = {{2{override_i.autozero_cal}}, override_i.filter_update,
                   {5{override_i.first_postcursor}}, {4{override_i.precursor}},
                   {4{override_i.second_postcursor}}};

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_bit
            assign applied_d[gi] = mask[gi] ? manual_i[gi] : internal_i[gi]; // R13
        end
    endgenerate

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            applied_q <= '0;
        end else begin
            applied_q <= applied_d;
        end
    end

    assign applied_o = rxclk_gate_pkg::tap_set_t'(applied_q);

    AST_OVERRIDE_SEL: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R13
        override_i.precursor |=> applied_o.final_precursor_weight == $past(manual_i.final_precursor_weight))
        else $error("precursor override not applied");

endmodule
`default_nettype wire

/* logic/rxclk_gate_regs.sv */
// Recovered clock gating control and high-speed tap final status registers.
// Assumes the management frame engine hands over decoded 16-bit accesses on
// this clock, and the lock and loss-of-signal levels are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module rxclk_gate_regs (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Management access
    input wire rxclk_gate_pkg::mgmt_req_t mgmt_req_i,
    output rxclk_gate_pkg::mgmt_rsp_t mgmt_rsp_o,
    // Analog status levels
    input wire logic hs_pll_locked_i,
    input wire logic high_speed_signal_loss_i,
    // Serializer setting sources
    input wire rxclk_gate_pkg::tap_override_t tap_override_i,
    input wire rxclk_gate_pkg::tap_set_t tap_manual_i,
    input wire rxclk_gate_pkg::tap_set_t tap_internal_i,
    // Controls towards the recovered clock output and the serializer
    output logic recovered_clock_output_hold_o,
    output logic recovered_clock_output_buf_off_o,
    output rxclk_gate_pkg::tap_set_t tap_applied_o,
    // Reserved control contents
    output logic [15:0] rsvd_ctrl_a_o,
    output logic [15:0] rsvd_ctrl_b_o,
    output logic [15:0] rsvd_ctrl_c_o
);

    ////////////////////////////////////////////////////////////////////////
    // Fault detection

    logic [1:0] level_sync;
    logic fault;

    fault_sync #(
        .WIDTH(2)
    ) u_fault_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i({hs_pll_locked_i, high_speed_signal_loss_i}),
        .sync_o(level_sync)
    );

    assign fault = !level_sync[1] || level_sync[0];

    ////////////////////////////////////////////////////////////////////////
    // Applied serializer settings

    rxclk_gate_pkg::tap_set_t applied;

    tap_select u_tap_select (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .override_i(tap_override_i),
        .manual_i(tap_manual_i),
        .internal_i(tap_internal_i),
        .applied_o(applied)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    logic [rxclk_gate_pkg::CTRL_W-1:0] ctrl_d;
    logic [rxclk_gate_pkg::CTRL_W-1:0] ctrl_q;
    logic [15:0] rsvd_d [rxclk_gate_pkg::NUM_RSVD];
    logic [15:0] rsvd_q [rxclk_gate_pkg::NUM_RSVD];
    logic [15:0] rsvd_ofs [rxclk_gate_pkg::NUM_RSVD];

    assign rsvd_ofs[0] = rxclk_gate_pkg::OFS_RSVD_A;
    assign rsvd_ofs[1] = rxclk_gate_pkg::OFS_RSVD_B;
    assign rsvd_ofs[2] = rxclk_gate_pkg::OFS_RSVD_C;

    // Bits 6 and 5 come up zero; software is trusted to set them
    always_comb begin
        ctrl_d = ctrl_q;
        if (mgmt_req_i.wr && mgmt_req_i.addr == rxclk_gate_pkg::OFS_GATING_CTRL) begin
            ctrl_d = mgmt_req_i.wdata[rxclk_gate_pkg::CTRL_W-1:0];
        end
    end

    genvar gr;
    generate
        for (gr = 0; gr < rxclk_gate_pkg::NUM_RSVD; gr++) begin : g_rsvd
            always_comb begin
                rsvd_d[gr] = rsvd_q[gr];
                if (mgmt_req_i.wr && mgmt_req_i.addr == rsvd_ofs[gr]) begin
                    rsvd_d[gr] = mgmt_req_i.wdata; // R12
                end
            end

            always_ff @(posedge clk_sys_i or posedge rst_i) begin
                if (rst_i) begin
                    rsvd_q[gr] <= rxclk_gate_pkg::RSVD_RST; // R12
                end else begin
                    rsvd_q[gr] <= rsvd_d[gr];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= rxclk_gate_pkg::GATING_CTRL_RST; // R7
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock output gating

    logic hold_d;
    logic hold_q;
    logic buf_off_d;
    logic buf_off_q;

    // Registered so the pad controls never glitch on a decode change
    always_comb begin
        hold_d = ctrl_q[rxclk_gate_pkg::BIT_FLATLINE_EN] && fault; // R1 R2
        buf_off_d = ctrl_q[rxclk_gate_pkg::BIT_BUF_OFF_EN] && fault; // R3 R4
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            hold_q <= 1'b0;
            buf_off_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            buf_off_q <= buf_off_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    rxclk_gate_pkg::mgmt_rsp_t rsp_d;
    rxclk_gate_pkg::mgmt_rsp_t rsp_q;

    always_comb begin
        rsp_d.valid = mgmt_req_i.rd;
        rsp_d.rdata = rxclk_gate_pkg::UNMAPPED_VAL;
        case (mgmt_req_i.addr)
            rxclk_gate_pkg::OFS_GATING_CTRL: begin
                rsp_d.rdata = {{(16 - rxclk_gate_pkg::CTRL_W){1'b0}}, ctrl_q};
            end
            rxclk_gate_pkg::OFS_RSVD_A: begin
                rsp_d.rdata = rsvd_q[0];
            end
            rxclk_gate_pkg::OFS_RSVD_B: begin
                rsp_d.rdata = rsvd_q[1];
            end
            rxclk_gate_pkg::OFS_RSVD_C: begin
                rsp_d.rdata = rsvd_q[2];
            end
            rxclk_gate_pkg::OFS_RSVD_READBACK: begin
                rsp_d.rdata = rxclk_gate_pkg::READBACK_VAL;
            end
            rxclk_gate_pkg::OFS_TAP_STATUS: begin
                rsp_d.rdata = applied; // R8 R9 R10 R11 R14
            end
            default: begin
                rsp_d.rdata = rxclk_gate_pkg::UNMAPPED_VAL;
            end
        endcase
        if (!mgmt_req_i.rd) begin
            rsp_d.rdata = rxclk_gate_pkg::UNMAPPED_VAL;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign mgmt_rsp_o = rsp_q;
    assign recovered_clock_output_hold_o = hold_q;
    assign recovered_clock_output_buf_off_o = buf_off_q;
    assign tap_applied_o = applied;
    assign rsvd_ctrl_a_o = rsvd_q[0];
    assign rsvd_ctrl_b_o = rsvd_q[1];
    assign rsvd_ctrl_c_o = rsvd_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    logic first_q;
    logic rd_status;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    assign rd_status = mgmt_req_i.rd && mgmt_req_i.addr == rxclk_gate_pkg::OFS_TAP_STATUS;

    AST_HOLD_ON_FAULT: assert property ( // R1
        ctrl_q[rxclk_gate_pkg::BIT_FLATLINE_EN] && fault |=> recovered_clock_output_hold_o)
        else $error("clock not held on fault");

    AST_NO_HOLD_DISABLED: assert property ( // R2
        !ctrl_q[rxclk_gate_pkg::BIT_FLATLINE_EN] |=> !recovered_clock_output_hold_o)
        else $error("clock held while flatline disabled");

    AST_BUF_OFF_ON_FAULT: assert property ( // R3
        ctrl_q[rxclk_gate_pkg::BIT_BUF_OFF_EN] && $past(level_sync[1]) && !level_sync[1]
        |=> recovered_clock_output_buf_off_o)
        else $error("buffer not powered down on lock loss");

    AST_BUF_ON_DISABLED: assert property ( // R4
        !ctrl_q[rxclk_gate_pkg::BIT_BUF_OFF_EN] |=> !recovered_clock_output_buf_off_o)
        else $error("buffer powered down while disabled");

    AST_CTRL_RESET: assert property ( // R7
        first_q |-> ctrl_q == rxclk_gate_pkg::GATING_CTRL_RST)
        else $error("gating control reset value wrong");

    AST_STATUS_CAL: assert property ( // R8
        rd_status |=> mgmt_rsp_o.rdata[15:13] == $past({applied.final_autozero_cal,
                                                         applied.final_filter_update}))
        else $error("cal or filter update field wrong");

    AST_STATUS_POST1: assert property ( // R9
        rd_status |=> mgmt_rsp_o.rdata[12:8] == $past(applied.final_first_postcursor_weight))
        else $error("first postcursor field wrong");

    AST_STATUS_PRE: assert property ( // R10
        rd_status |=> mgmt_rsp_o.rdata[7:4] == $past(applied.final_precursor_weight))
        else $error("precursor field wrong");

    AST_STATUS_POST2: assert property ( // R11
        rd_status |=> mgmt_rsp_o.valid && mgmt_rsp_o.rdata[3:0] == $past(applied.final_second_postcursor_weight))
        else $error("second postcursor field wrong");

    AST_RSVD_WRITE: assert property ( // R12
        mgmt_req_i.wr && mgmt_req_i.addr == rxclk_gate_pkg::OFS_RSVD_B
        |=> rsvd_ctrl_b_o == $past(mgmt_req_i.wdata))
        else $error("reserved control write lost");

    AST_STATUS_TRACKS: assert property ( // R14
        !tap_override_i.second_postcursor ##1 !tap_override_i.second_postcursor
        |-> tap_applied_o.final_second_postcursor_weight == $past(tap_internal_i.final_second_postcursor_weight))
        else $error("status does not follow internal value");

    AST_HOLD_ON_SIGNAL_LOSS: assert property ( // R1
        ctrl_q[rxclk_gate_pkg::BIT_FLATLINE_EN] && level_sync[0] |=> recovered_clock_output_hold_o)
        else $error("clock not held on signal loss");

    AST_BUF_OFF_ON_SIGNAL_LOSS: assert property ( // R3
        ctrl_q[rxclk_gate_pkg::BIT_BUF_OFF_EN] && level_sync[0] |=> recovered_clock_output_buf_off_o)
        else $error("buffer not powered down on signal loss");

    AST_NO_HOLD_HEALTHY: assert property ( // R1
        level_sync[1] && !level_sync[0] |=> !recovered_clock_output_hold_o)
        else $error("clock held with lock present and signal seen");

    AST_BUF_ON_HEALTHY: assert property ( // R3
        level_sync[1] && !level_sync[0] |=> !recovered_clock_output_buf_off_o)
        else $error("buffer powered down with no fault");

    AST_CTRL_WRITE: assert property ( // R6
        mgmt_req_i.wr && mgmt_req_i.addr == rxclk_gate_pkg::OFS_GATING_CTRL
        |=> ctrl_q == $past(mgmt_req_i.wdata[rxclk_gate_pkg::CTRL_W-1:0]))
        else $error("gating control write lost");

    AST_CTRL_KEEP: assert property ( // R5
        !(mgmt_req_i.wr && mgmt_req_i.addr == rxclk_gate_pkg::OFS_GATING_CTRL) |=> $stable(ctrl_q))
        else $error("gating control changed without a write");

    AST_RSVD_A_WRITE: assert property ( // R12
        mgmt_req_i.wr && mgmt_req_i.addr == rxclk_gate_pkg::OFS_RSVD_A
        |=> rsvd_ctrl_a_o == $past(mgmt_req_i.wdata))
        else $error("reserved control a write lost");

    AST_RSVD_C_WRITE: assert property ( // R12
        mgmt_req_i.wr && mgmt_req_i.addr == rxclk_gate_pkg::OFS_RSVD_C
        |=> rsvd_ctrl_c_o == $past(mgmt_req_i.wdata))
        else $error("reserved control c write lost");

    AST_RSVD_A_KEEP: assert property ( // R12
        !(mgmt_req_i.wr && mgmt_req_i.addr == rxclk_gate_pkg::OFS_RSVD_A) |=> $stable(rsvd_ctrl_a_o))
        else $error("reserved control a changed without a write");

    AST_RSVD_RESET: assert property ( // R12
        first_q |-> rsvd_ctrl_a_o == rxclk_gate_pkg::RSVD_RST && rsvd_ctrl_b_o == rxclk_gate_pkg::RSVD_RST
        && rsvd_ctrl_c_o == rxclk_gate_pkg::RSVD_RST)
        else $error("reserved control reset value wrong");

    AST_RSP_IDLE: assert property ( // R8
        !mgmt_req_i.rd |=> !mgmt_rsp_o.valid && mgmt_rsp_o.rdata == rxclk_gate_pkg::UNMAPPED_VAL)
        else $error("read answer without a read");

    COV_HOLD: cover property (!recovered_clock_output_hold_o ##1 recovered_clock_output_hold_o);
    COV_BUF_OFF: cover property (recovered_clock_output_buf_off_o ##1 !recovered_clock_output_buf_off_o);
    COV_STATUS_RD: cover property (rd_status ##1 mgmt_rsp_o.rdata != 16'h0000);
    COV_CTRL_CLEAR: cover property (!ctrl_q[rxclk_gate_pkg::BIT_FLATLINE_EN] && fault);
    COV_SIGNAL_LOSS: cover property (level_sync[0] ##1 recovered_clock_output_buf_off_o);

endmodule
`default_nettype wire

/* bench/mgmt_station.sv */
// Management station model: issues single-word accesses on the decoded port.
// Assumes requests are sampled on the rising clock edge, answers a cycle later.
`timescale 1ns/1ps
`default_nettype none

module mgmt_station (
    // Clock
    input wire logic clk_sys_i,
    // Access port
    output var rxclk_gate_pkg::mgmt_req_t mgmt_req_o,
    input wire rxclk_gate_pkg::mgmt_rsp_t mgmt_rsp_i
);
    initial mgmt_req_o = '0;

    // Idle address and data are inverted so a stale value never looks valid
    task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
        @(posedge clk_sys_i);
        mgmt_req_o <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge clk_sys_i);
        mgmt_req_o <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data};
    endtask

    task automatic read_reg(input logic [15:0] addr, output logic [15:0] data);
        @(posedge clk_sys_i);
        mgmt_req_o <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(posedge clk_sys_i);
        mgmt_req_o <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: 16'hffff};
        #1;
        data = mgmt_rsp_i.valid === 1'b1 ? mgmt_rsp_i.rdata : 16'hxxxx;
    endtask

    // Bring-up: enables and bits 1:0 kept at one, bits 6 and 5 set to one
    task automatic init();
        write_reg(rxclk_gate_pkg::OFS_GATING_CTRL, 16'h006f);
    endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the recovered clock gating and tap status registers.
// Assumes the station model is the only source of management accesses.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_sys_i;
    logic rst_i;
    rxclk_gate_pkg::mgmt_req_t mgmt_req;
    rxclk_gate_pkg::mgmt_rsp_t mgmt_rsp;
    logic locked;
    logic loss;
    rxclk_gate_pkg::tap_override_t ovr;
    rxclk_gate_pkg::tap_set_t man_v;
    rxclk_gate_pkg::tap_set_t int_v;
    logic hold;
    logic buf_off;
    rxclk_gate_pkg::tap_set_t applied;
    logic [15:0] rsvd [3];
    int num_errors = 0;
    int check_count = 0;

    rxclk_gate_regs rxclk_gate_regs_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .mgmt_req_i(mgmt_req), .mgmt_rsp_o(mgmt_rsp),
        .hs_pll_locked_i(locked), .high_speed_signal_loss_i(loss),
        .tap_override_i(ovr), .tap_manual_i(man_v), .tap_internal_i(int_v),
        .recovered_clock_output_hold_o(hold), .recovered_clock_output_buf_off_o(buf_off),
        .tap_applied_o(applied),
        .rsvd_ctrl_a_o(rsvd[0]), .rsvd_ctrl_b_o(rsvd[1]), .rsvd_ctrl_c_o(rsvd[2])
    );

    mgmt_station mgmt_station_i (
        .clk_sys_i(clk_sys_i), .mgmt_req_o(mgmt_req), .mgmt_rsp_i(mgmt_rsp)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        mgmt_station_i.read_reg(a, v);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values();
        logic [15:0] v;
        logic [15:0] ofs [5];
        ofs = '{rxclk_gate_pkg::OFS_RSVD_A, rxclk_gate_pkg::OFS_RSVD_B, rxclk_gate_pkg::OFS_RSVD_C,
                rxclk_gate_pkg::OFS_RSVD_READBACK, 16'h8025};
        rd(rxclk_gate_pkg::OFS_GATING_CTRL, v);
        check("gating_ctrl", v, 16'h000f);
        foreach (ofs[i]) begin
            rd(ofs[i], v);
            check("reset_word", v, 16'h0000);
        end
        $display("test reset values done");
    endtask

    task automatic test_register_access();
        logic [15:0] v;
        mgmt_station_i.init();
        rd(rxclk_gate_pkg::OFS_GATING_CTRL, v);
        check("gating_ctrl", v, 16'h006f);
        mgmt_station_i.write_reg(rxclk_gate_pkg::OFS_GATING_CTRL, 16'hff6f);
        rd(rxclk_gate_pkg::OFS_GATING_CTRL, v);
        check("gating_ctrl_hi", v, 16'h006f);
        for (int i = 0; i < 3; i++) begin
            mgmt_station_i.write_reg(16'h8022 + 16'(i), 16'ha5c3 ^ 16'(i));
        end
        for (int i = 0; i < 3; i++) begin
            rd(16'h8022 + 16'(i), v);
            check("rsvd_read", v, 16'ha5c3 ^ 16'(i));
            check("rsvd_out", rsvd[i], 16'ha5c3 ^ 16'(i));
        end
        mgmt_station_i.write_reg(rxclk_gate_pkg::OFS_RSVD_READBACK, 16'hffff);
        rd(rxclk_gate_pkg::OFS_RSVD_READBACK, v);
        check("readback", v, 16'h0000);
        $display("test register access done");
    endtask

    // Each gating setting against each fault source, then recovery
    task automatic test_fault_gating();
        logic [15:0] ctrl [4];
        ctrl = '{16'h006f, 16'h0067, 16'h006b, 16'h0063};
        foreach (ctrl[i]) begin
            mgmt_station_i.write_reg(rxclk_gate_pkg::OFS_GATING_CTRL, ctrl[i]);
            for (int f = 0; f < 2; f++) begin
                @(posedge clk_sys_i);
                locked <= (f != 0);
                loss <= (f != 0);
                repeat (3) @(posedge clk_sys_i);
                #1;
                check("hold", {15'h0, hold}, {15'h0, ctrl[i][3]});
                check("buf_off", {15'h0, buf_off}, {15'h0, ctrl[i][2]});
                @(posedge clk_sys_i);
                locked <= 1'b1;
                loss <= 1'b0;
                repeat (3) @(posedge clk_sys_i);
                #1;
                check("hold_clear", {15'h0, hold}, 16'h0000);
                check("buf_clear", {15'h0, buf_off}, 16'h0000);
            end
        end
        mgmt_station_i.init();
        $display("test fault gating done");
    endtask

    // Every override combination; status must follow the mux with no latching
    task automatic test_tap_status();
        logic [15:0] v;
        logic [15:0] m;
        logic [15:0] field [5];
        field = '{16'h000f, 16'h00f0, 16'h1f00, 16'h2000, 16'hc000};
        for (int o = 0; o < 32; o++) begin
            m = 16'h0000;
            for (int b = 0; b < 5; b++) begin
                if (o[b]) begin
                    m = m | field[b];
                end
            end
            @(posedge clk_sys_i);
            ovr <= 5'(o);
            man_v <= 16'ha5c3 ^ 16'(o);
            int_v <= 16'h5a3c + 16'(o);
            rd(rxclk_gate_pkg::OFS_TAP_STATUS, v);
            check("tap_status", v, ((16'ha5c3 ^ 16'(o)) & m) | ((16'h5a3c + 16'(o)) & ~m));
            check("tap_applied", applied, ((16'ha5c3 ^ 16'(o)) & m) | ((16'h5a3c + 16'(o)) & ~m));
        end
        mgmt_station_i.write_reg(rxclk_gate_pkg::OFS_TAP_STATUS, 16'h0000);
        rd(rxclk_gate_pkg::OFS_TAP_STATUS, v);
        check("tap_ro", v, 16'ha5c3 ^ 16'h001f);
        $display("test tap status done");
    endtask

    // Reset in mid-run must bring every register back to its reset value
    task automatic test_mid_reset();
        mgmt_station_i.write_reg(rxclk_gate_pkg::OFS_RSVD_A, 16'h1234);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        check("rsvd_a_rst", rsvd[0], 16'h0000);
        rst_i <= 1'b0;
        test_reset_values();
        mgmt_station_i.init();
        $display("test mid reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        locked = 1'b1;
        loss = 1'b0;
        ovr = '0;
        man_v = '0;
        int_v = '0;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        test_reset_values();
        test_register_access();
        test_fault_gating();
        test_tap_status();
        test_mid_reset();
        give_verdict();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
